// >>> adp_pkg.sv
package adp_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W     = 12;              // Output word width
  localparam int SIGN_BIT   = 11;              // Sign bit of the twos-complement word
  localparam int ENTRY_W    = 13;              // Word plus overrange bit
  localparam int OVR_BIT    = 12;              // Overrange bit position in an entry

  // ----------------------------------------------------------------
  // Pipeline and buffering
  // ----------------------------------------------------------------
  localparam int LATENCY    = 74;              // Encode cycles from sample to output
  localparam int OUT_DEPTH  = 4;               // Output FIFO depth

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ         = 10000;      // System clock rate in kHz
  localparam int STARTUP_MS      = 600;        // Longest recovery after reset, ms
  localparam int STARTUP_CYCLES  = STARTUP_MS * CLK_KHZ; // Rounded down, exact here
  localparam int RESET_MIN_NS    = 200;        // Least reset pulse from the partner
  localparam int GATE_LOW_MIN_NS = 5;          // Least asynchronous gate low time

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RST = 12'h000; // Mid-scale code
  localparam logic              GATE_RST = 1'b1;    // Gate reads high when idle

  // ----------------------------------------------------------------
  // Output stage states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_RUN     = 2'b01,
    ST_GATED   = 2'b10
  } adp_state_t;

endpackage

// >>> adp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module adp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Pointer helper
  // ----------------------------------------------------------------
  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(DEPTH - 1)) begin
      next_ptr = '0;
    end else begin
      next_ptr = p + PTR_W'(1);
    end
  endfunction

  // Full FIFO still takes a word when the head leaves in the same cycle
  assign out_valid = (count_q != '0);
  assign in_ready  = (count_q != CNT_W'(DEPTH)) || out_ready;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Head word held in a register: taken from the input when the FIFO is
  // empty or about to be, otherwise from the next slot on a pop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= '0;
    end else if (push && ((count_q == '0) || (pop && (count_q == CNT_W'(1))))) begin
      out_data <= in_data;
    end else if (pop) begin
      out_data <= mem_q[next_ptr(rd_ptr_q)];
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + CNT_W'(1);
      end else if (pop && !push) begin
        count_q <= count_q - CNT_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// >>> adp_output_port.sv
// Overview of operation
// - Samples leave as twos-complement twelve-bit words
// - Outputs become valid within 600 ms after reset
// - Sample emerges 74 encode cycles after capture
// - Gate low freezes both data strobes
// - Strobes restart at next channel A word, B strobe on the word after
// - Words produced while gated are discarded
// - Idle or floating gate reads as high
// - Overrange pair: true high when overranged
// - Channel B word as true/complement pairs
// - Each channel has its own strobe pair
// - Channel A word as true/complement pairs
`timescale 1ns/100ps
`default_nettype none
module adp_output_port
  import adp_pkg::*;
#(
  parameter int LATENCY_CYC = adp_pkg::LATENCY,
  parameter int STARTUP_CYC = adp_pkg::STARTUP_CYCLES,
  parameter int FIFO_DEPTH  = adp_pkg::OUT_DEPTH
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        encode_clk,
  input  wire logic [adp_pkg::WORD_W-1:0]  raw_sample,
  input  wire logic                        raw_overrange,
  input  wire logic                        data_ready_gate,
  output logic      [adp_pkg::WORD_W-1:0]  chan_a_word_p,
  output logic      [adp_pkg::WORD_W-1:0]  chan_a_word_n,
  output logic      [adp_pkg::WORD_W-1:0]  chan_b_word_p,
  output logic      [adp_pkg::WORD_W-1:0]  chan_b_word_n,
  output logic                             chan_a_data_strobe_p,
  output logic                             chan_a_data_strobe_n,
  output logic                             chan_b_data_strobe_p,
  output logic                             chan_b_data_strobe_n,
  output logic                             overrange_flag_p,
  output logic                             overrange_flag_n,
  output logic                             port_ready,
  output logic                             sample_dropped
);

  localparam int STC_W = $clog2(STARTUP_CYC + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic               enc_s1_q;
  logic               enc_s2_q;
  logic               enc_s3_q;
  logic               gate_s1_q;
  logic               gate_s2_q;
  logic               enc_rise;
  logic               enc_fall;
  logic [ENTRY_W-1:0] cap_entry;
  logic               dly_in_ready;
  logic               dly_out_valid;
  logic [ENTRY_W-1:0] dly_out_data;
  logic               dly_in_valid;
  logic               dly_out_ready;
  logic               dly_full;
  logic               out_in_ready;
  logic               out_out_valid;
  logic               out_out_ready;
  logic [ENTRY_W-1:0] out_out_data;
  logic [7:0]         dly_level_q;
  logic [STC_W-1:0]   startup_cnt_q;
  adp_state_t         state_q;
  adp_state_t         state_d;
  logic               sel_b_q;
  logic               deliver;
  logic               drop_q;
  logic [ENTRY_W-1:0] raw_s1_q;
  logic [ENTRY_W-1:0] raw_s2_q;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Offset-binary core code to twos complement: flip the sign bit
  function automatic logic [WORD_W-1:0] to_twos(input logic [WORD_W-1:0] code);
    to_twos = {~code[SIGN_BIT], code[SIGN_BIT-1:0]};
  endfunction

  // Start-up check shared by the drain and the ready pin
  function automatic logic is_live(input adp_state_t st);
    is_live = (st != ST_STARTUP);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Encode clock: two stages, then a third for edge finding
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enc_s1_q <= 1'b0;
      enc_s2_q <= 1'b0;
      enc_s3_q <= 1'b0;
    end else begin
      enc_s1_q <= encode_clk;
      enc_s2_q <= enc_s1_q;
      enc_s3_q <= enc_s2_q;
    end
  end

  // Edges come from the last two stages, so a pulse under one clock is lost
  assign enc_rise = enc_s2_q && !enc_s3_q;
  assign enc_fall = !enc_s2_q && enc_s3_q;

  // Gate synchroniser resets high so an undriven gate lets strobes run
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_s1_q <= GATE_RST;
      gate_s2_q <= GATE_RST;
    end else begin
      gate_s1_q <= data_ready_gate;
      gate_s2_q <= gate_s1_q;
    end
  end

  // Sample word and overrange: two stages as well; the word settles well
  // before the synced encode edge that captures it, so no bit is caught moving
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      raw_s1_q <= '0;
      raw_s2_q <= '0;
    end else begin
      raw_s1_q <= {raw_overrange, raw_sample};
      raw_s2_q <= raw_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Capture and latency line
  // ----------------------------------------------------------------
  assign cap_entry     = {raw_s2_q[OVR_BIT], to_twos(raw_s2_q[WORD_W-1:0])};
  // Level stops at the depth; from then on each encode edge with room in the output buffer pushes and pops
  assign dly_full      = (dly_level_q == 8'(LATENCY_CYC));
  // Once primed, each encode edge with room in the output buffer pushes one sample and retires the oldest
  assign dly_in_valid  = enc_rise;
  assign dly_out_ready = enc_rise && dly_full && out_in_ready;

  // Fill level of the latency line, held at its depth once primed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dly_level_q <= 8'h00;
    end else if (enc_rise && dly_in_ready && !dly_full) begin
      dly_level_q <= dly_level_q + 8'h01;
    end
  end

  // Sample refused because the output buffer stalled the line
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= enc_rise && !dly_in_ready;
    end
  end

  assign sample_dropped = drop_q;

  // Latency line: one entry per encode edge, as deep as the pipeline latency
  adp_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (LATENCY_CYC)
  ) u_delay (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (dly_in_valid),
    .in_ready  (dly_in_ready),
    .in_data   (cap_entry),
    .out_valid (dly_out_valid),
    .out_ready (dly_out_ready),
    .out_data  (dly_out_data)
  );

  // Output buffer between the latency line and the pin stage
  adp_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_outbuf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (dly_out_valid && dly_out_ready),
    .in_ready  (out_in_ready),
    .in_data   (dly_out_data),
    .out_valid (out_out_valid),
    .out_ready (out_out_ready),
    .out_data  (out_out_data)
  );

  // ----------------------------------------------------------------
  // Start-up interval
  // ----------------------------------------------------------------
  // Counts after reset release; pins stay quiet until it expires
  // Counting stops once running, so the counter never wraps
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      startup_cnt_q <= '0;
    end else if (state_q == ST_STARTUP) begin
      startup_cnt_q <= startup_cnt_q + STC_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Pin stage state machine
  // ----------------------------------------------------------------
  // Drain runs on the falling encode edge; buffer stalls during start-up
  assign out_out_ready = enc_fall && is_live(state_q);
  assign deliver       = out_out_ready && out_out_valid && gate_s2_q &&
                         ((state_q == ST_RUN) || !sel_b_q);

  // Gated state releases only on an A slot, so a resumed stream never opens on B
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STARTUP: begin
        if (startup_cnt_q >= STC_W'(STARTUP_CYC - 1)) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!gate_s2_q) begin
          state_d = ST_GATED;
        end
      end
      ST_GATED: begin
        if (deliver) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_STARTUP;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_STARTUP;
    end else begin
      state_q <= state_d;
    end
  end

  assign port_ready = is_live(state_q);

  // Channel selector steps on every word, delivered or discarded
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_b_q <= 1'b0;
    end else if (out_out_ready && out_out_valid) begin
      sel_b_q <= !sel_b_q;
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  // Complement halves are registered too, so both sides of a pair switch together
  // Channel A word (msb at bit 11, lsb at bit 0) and its strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_a_word_p        <= WORD_RST;
      chan_a_word_n        <= ~WORD_RST;
      chan_a_data_strobe_p <= 1'b0;
      chan_a_data_strobe_n <= 1'b1;
    end else if (deliver && !sel_b_q) begin
      chan_a_word_p        <= out_out_data[WORD_W-1:0];
      chan_a_word_n        <= ~out_out_data[WORD_W-1:0];
      chan_a_data_strobe_p <= !chan_a_data_strobe_p;
      chan_a_data_strobe_n <= chan_a_data_strobe_p;
    end
  end

  // Channel B word (msb at bit 11, lsb at bit 0) and its strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_b_word_p        <= WORD_RST;
      chan_b_word_n        <= ~WORD_RST;
      chan_b_data_strobe_p <= 1'b0;
      chan_b_data_strobe_n <= 1'b1;
    end else if (deliver && sel_b_q) begin
      chan_b_word_p        <= out_out_data[WORD_W-1:0];
      chan_b_word_n        <= ~out_out_data[WORD_W-1:0];
      chan_b_data_strobe_p <= !chan_b_data_strobe_p;
      chan_b_data_strobe_n <= chan_b_data_strobe_p;
    end
  end

  // Overrange follows the most recent delivered word; gated words are lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overrange_flag_p <= 1'b0;
      overrange_flag_n <= 1'b1;
    end else if (deliver) begin
      overrange_flag_p <= out_out_data[OVR_BIT];
      overrange_flag_n <= !out_out_data[OVR_BIT];
    end
  end

endmodule
`default_nettype wire

// >>> adp_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module adp_port_monitor
  import adp_pkg::*;
#(
  parameter int STARTUP_CYC = 50
) (
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire logic                       encode_clk,
  input wire logic [adp_pkg::WORD_W-1:0] raw_sample,
  input wire logic                       raw_overrange,
  input wire logic                       data_ready_gate,
  input wire logic [adp_pkg::WORD_W-1:0] chan_a_word_p,
  input wire logic [adp_pkg::WORD_W-1:0] chan_a_word_n,
  input wire logic [adp_pkg::WORD_W-1:0] chan_b_word_p,
  input wire logic [adp_pkg::WORD_W-1:0] chan_b_word_n,
  input wire logic                       chan_a_data_strobe_p,
  input wire logic                       chan_a_data_strobe_n,
  input wire logic                       chan_b_data_strobe_p,
  input wire logic                       chan_b_data_strobe_n,
  input wire logic                       overrange_flag_p,
  input wire logic                       overrange_flag_n,
  input wire logic                       port_ready,
  input wire logic                       sample_dropped
);
  int ready_cnt_q;

  // Cycles since reset release while start-up is pending
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready_cnt_q <= 0;
    end else if (!port_ready) begin
      ready_cnt_q <= ready_cnt_q + 1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Output pairs, start-up and gating
  // ----------------------------------------------------------------
  a_word_a_pair: assert property (chan_a_word_n == ~chan_a_word_p)
    else $error("channel A word pair not complementary");
  a_word_b_pair: assert property (chan_b_word_n == ~chan_b_word_p)
    else $error("channel B word pair not complementary");
  a_strobe_pairs: assert property ((chan_a_data_strobe_n != chan_a_data_strobe_p) &&
    (chan_b_data_strobe_n != chan_b_data_strobe_p)) else $error("strobe pair not complementary");
  a_ovr_pair: assert property (overrange_flag_n != overrange_flag_p)
    else $error("overrange pair not complementary");
  a_ready_time: assert property ($rose(port_ready) |->
    (ready_cnt_q >= STARTUP_CYC - 1) && (ready_cnt_q <= STARTUP_CYC + 2)) else $error("ready at wrong time");
  a_ready_bound: assert property (!port_ready |-> ready_cnt_q <= STARTUP_CYC + 2)
    else $error("start-up interval too long");
  a_ready_stays: assert property (port_ready |=> port_ready)
    else $error("ready dropped without reset");
  a_quiet_startup: assert property (!port_ready |=>
    $stable(chan_a_data_strobe_p) && $stable(chan_b_data_strobe_p)) else $error("strobe during start-up");
  a_gate_freeze: assert property ((!data_ready_gate) [*6] |->
    $stable(chan_a_data_strobe_p) && $stable(chan_b_data_strobe_p)) else $error("strobe while gated");
  a_one_channel: assert property (!($changed(chan_a_data_strobe_p) &&
    $changed(chan_b_data_strobe_p))) else $error("both channels updated together");

  c_ready: cover property ($rose(port_ready));
  c_gated: cover property ((!data_ready_gate) [*6]);
  c_a_then_b: cover property ($changed(chan_a_data_strobe_p) ##[1:12] $changed(chan_b_data_strobe_p));
endmodule
`default_nettype wire

// >>> adp_capture_model.sv
`timescale 1ns/100ps
`default_nettype none
module adp_capture_model
  import adp_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       port_ready,
  input  wire logic [adp_pkg::WORD_W-1:0] word_a,
  input  wire logic [adp_pkg::WORD_W-1:0] word_b,
  input  wire logic                       strobe_a,
  input  wire logic                       strobe_b,
  input  wire logic                       ovr,
  output logic                            cap_valid,
  output logic                            cap_chan_b,
  output logic      [adp_pkg::WORD_W-1:0] cap_word,
  output logic                            cap_ovr
);
  logic seen_a_q;
  logic seen_b_q;

  // Latch a word on either edge of its strobe, ignoring output until ready
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_a_q   <= 1'b0;
      seen_b_q   <= 1'b0;
      cap_valid  <= 1'b0;
      cap_chan_b <= 1'b0;
      cap_word   <= 12'h000;
      cap_ovr    <= 1'b0;
    end else begin
      seen_a_q   <= strobe_a;
      seen_b_q   <= strobe_b;
      cap_valid  <= port_ready && ((seen_a_q != strobe_a) || (seen_b_q != strobe_b));
      cap_chan_b <= (seen_b_q != strobe_b);
      cap_word   <= (seen_b_q != strobe_b) ? word_b : word_a;
      cap_ovr    <= ovr;
    end
  end
endmodule
`default_nettype wire

// >>> test_adp_output_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_adp_output_port;
  import adp_pkg::*;
  localparam int STUP   = 50;
  localparam int LAT_LO = LATENCY * 8 + 4;   // Capture lag window, clk cycles
  localparam int LAT_HI = LATENCY * 8 + 11;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic              encode_clk = 1'b0;
  logic [WORD_W-1:0] raw_sample = 12'h000;
  logic              raw_overrange = 1'b0;
  logic              data_ready_gate = 1'b1;   // Pull-up level when unused
  logic [WORD_W-1:0] a_p, a_n, b_p, b_n, cap_word, r_s;
  logic              sa_p, sa_n, sb_p, sb_n, ov_p, ov_n, port_ready, sample_dropped;
  logic              cap_valid, cap_chan_b, cap_ovr, o_s;
  logic [2:0]        phase = 3'h0;
  int                errors = 0, cmp_count = 0, seed = 38, cycles = 0, enc_idx = 0, skipped, lag;
  bit                run_enc = 1'b0, lossy = 1'b0, expect_a = 1'b1;
  logic [WORD_W-1:0] exp_word[$];
  logic              exp_ovr[$];
  int                exp_cyc[$];
  logic [WORD_W-1:0] raw_tab[4] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF}; // Extremes, mid-scale

  adp_output_port #(.LATENCY_CYC(LATENCY), .STARTUP_CYC(STUP), .FIFO_DEPTH(OUT_DEPTH)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .encode_clk(encode_clk), .raw_sample(raw_sample),
    .raw_overrange(raw_overrange), .data_ready_gate(data_ready_gate),
    .chan_a_word_p(a_p), .chan_a_word_n(a_n), .chan_b_word_p(b_p), .chan_b_word_n(b_n),
    .chan_a_data_strobe_p(sa_p), .chan_a_data_strobe_n(sa_n), .chan_b_data_strobe_p(sb_p),
    .chan_b_data_strobe_n(sb_n), .overrange_flag_p(ov_p), .overrange_flag_n(ov_n),
    .port_ready(port_ready), .sample_dropped(sample_dropped));

  adp_capture_model u_cap (.clk_sys(clk_sys), .rst_n(rst_n), .port_ready(port_ready), .word_a(a_p),
    .word_b(b_p), .strobe_a(sa_p), .strobe_b(sb_p), .ovr(ov_p), .cap_valid(cap_valid),
    .cap_chan_b(cap_chan_b), .cap_word(cap_word), .cap_ovr(cap_ovr));

  // Clock and hang guard
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (cycles > 8000) begin
    errors++;
    wrap_up();
  end

  // Encode clock of 800 ns with a fresh sample noted on each rise
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    phase <= run_enc ? phase + 3'h1 : 3'h0;
    encode_clk <= run_enc && (phase < 3'h4);
    if (run_enc && phase == 3'h0) begin
      r_s = (enc_idx < 4) ? raw_tab[enc_idx] : 12'($random(seed));
      o_s = 1'($random(seed));
      raw_sample <= r_s;
      raw_overrange <= o_s;
      exp_word.push_back(r_s - 12'h800);   // Offset binary to twos complement
      exp_ovr.push_back(o_s);
      exp_cyc.push_back(cycles);
      enc_idx <= enc_idx + 1;
    end
  end

  task automatic cmp_word(logic [WORD_W-1:0] act, logic [WORD_W-1:0] exp, string msg);
    cmp_count++;
    if (act !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, act, exp);
    end
  endtask

  task automatic cmp_bit(logic act, logic exp, string msg);
    cmp_count++;
    if (act !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %b want %b", $time, msg, act, exp);
    end
  endtask

  // Match each captured word against the oldest noted sample
  always @(posedge clk_sys) if (cap_valid === 1'b1) begin
    if (lossy) begin
      skipped = 0;
      while (exp_word.size() > 0 && exp_word[0] !== cap_word) begin
        void'(exp_word.pop_front());
        void'(exp_ovr.pop_front());
        void'(exp_cyc.pop_front());
        skipped++;
      end
      cmp_bit(skipped >= 3, 1'b1, "gated words not dropped");
      lossy = 1'b0;
      expect_a = 1'b1;
    end
    if (exp_word.size() == 0) begin
      cmp_bit(1'b0, 1'b1, "word with no sample");
    end else begin
      cmp_word(cap_word, exp_word.pop_front(), "word");
      cmp_bit(cap_ovr, exp_ovr.pop_front(), "overrange");
      cmp_bit(cap_chan_b, !expect_a, "channel order");
      lag = cycles - exp_cyc.pop_front();
      cmp_bit(lag >= LAT_LO && lag <= LAT_HI, 1'b1, "latency");
      expect_a = !expect_a;
    end
  end

  // Once running at the encode rate no sample may be refused
  always @(posedge clk_sys) if (port_ready === 1'b1) begin
    cmp_bit(sample_dropped, 1'b0, "sample refused");
  end

  // Reset for eight cycles, check idle outputs and start-up interval
  task automatic do_reset;
    run_enc <= 1'b0;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    exp_word.delete();
    exp_ovr.delete();
    exp_cyc.delete();
    expect_a = 1'b1;
    cmp_word(a_p | b_p, 12'h000, "word in reset");
    cmp_bit(sa_p | sb_p | ov_p | port_ready | sample_dropped, 1'b0, "flags in reset");
    cmp_word(a_n & b_n, 12'hFFF, "complement word in reset");
    cmp_bit(sa_n & sb_n & ov_n, 1'b1, "complement flags in reset");
    rst_n <= 1'b1;
    repeat (STUP - 2) @(posedge clk_sys);
    cmp_bit(port_ready, 1'b0, "ready too early");
    repeat (5) @(posedge clk_sys);
    cmp_bit(port_ready, 1'b1, "ready too late");
    run_enc <= 1'b1;
  endtask

  task automatic wrap_up;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Stream, gate pause, mid-run reset, stream again
  initial begin
    do_reset();
    repeat (900) @(posedge clk_sys);
    do @(posedge clk_sys); while (phase != 3'h1);
    data_ready_gate <= 1'b0;
    repeat (40) @(posedge clk_sys);
    data_ready_gate <= 1'b1;
    lossy = 1'b1;
    repeat (400) @(posedge clk_sys);
    do_reset();
    repeat (700) @(posedge clk_sys);
    wrap_up();
  end
endmodule

bind adp_output_port adp_port_monitor #(.STARTUP_CYC(STARTUP_CYC)) u_mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .encode_clk(encode_clk), .raw_sample(raw_sample),
  .raw_overrange(raw_overrange), .data_ready_gate(data_ready_gate), .chan_a_word_p(chan_a_word_p),
  .chan_a_word_n(chan_a_word_n), .chan_b_word_p(chan_b_word_p), .chan_b_word_n(chan_b_word_n),
  .chan_a_data_strobe_p(chan_a_data_strobe_p), .chan_a_data_strobe_n(chan_a_data_strobe_n),
  .chan_b_data_strobe_p(chan_b_data_strobe_p), .chan_b_data_strobe_n(chan_b_data_strobe_n),
  .overrange_flag_p(overrange_flag_p), .overrange_flag_n(overrange_flag_n),
  .port_ready(port_ready), .sample_dropped(sample_dropped));
`default_nettype wire
